// File: src/rcs_command_source.sv
// Run command source selection: panel keys, terminals or serial control.
// Assumes all inputs synchronous to clk_in; serial bytes arrive already
// framed by a UART, with rx_gap_in pulsing on line silence between frames.
//
// Contract
// - Source setting 0 panel, 1 terminals, 2 serial link.
// - Indicator off for panel, on for terminals, flashing for serial.
// - Panel: run key starts motor, stop key stops it.
// - Terminal mode 0..3: two-wire 1, two-wire 2, three-wire 1, three-wire 2.
// - Two-wire 1: forward while input 1 closed, stop when open.
// - Two-wire 1: reverse while input 2 closed, stop when open.
// - Two-wire 1: both open or both closed stops motor.
// - Two-wire 2: input 1 enables run, input 2 picks direction.
// - Two-wire 2: enable open stops regardless of direction.
// - Three-wire 1: input 3 is the normally closed stop terminal.
// - Three-wire modes: stop input closed to run; opening stops at once.
// - Three-wire modes: buttons ignored unless stop input closed.
// - Three-wire 1: forward press runs forward, reverse press runs reverse.
// - Three-wire 2: run press starts, direction from input 2 level.
// - Run command is function 06H to address SERIAL_CONTROL_COMMAND; 02H means reverse.
// - Frame starts with slave address, ends with two CRC bytes.
`timescale 1ns/1ns

module rcs_command_source
   import rcs_pkg::*;
#(
   parameter int FLASH_CYC = FLASH_HALF_CYC
) (
   input  wire logic        clk_in,              // System clock, 125 MHz
   input  wire logic        sys_rst_in,          // Async reset, active high
   input  wire logic        ce_in,               // Clock enable, freezes all
   input  wire logic        set_wr_in,           // Setting write strobe
   input  wire logic [1:0]  set_idx_in,          // Setting index
   input  wire logic [15:0] set_data_in,         // Setting write data
   input  wire logic        run_key_in,          // Panel run key
   input  wire logic        stop_key_in,         // Panel stop key
   input  wire logic        digital_input_1_in,  // Terminal 1, 1 = closed
   input  wire logic        digital_input_2_in,  // Terminal 2, 1 = closed
   input  wire logic        digital_input_3_in,  // Terminal 3, 1 = closed
   input  wire logic [7:0]  rx_byte_in,          // Received serial byte
   input  wire logic        rx_valid_in,         // Received byte strobe
   input  wire logic        rx_gap_in,           // Line silence, frame boundary
   input  wire logic        tx_ready_in,         // Transmitter takes byte
   output logic [7:0]       tx_byte_out,         // Echo byte
   output logic             tx_valid_out,        // Echo byte valid
   output logic             motor_run_out,       // Motor run command
   output logic             motor_reverse_out,   // Reverse direction
   output logic             source_indicator_led_out, // Local/remote lamp
   output logic             frame_error_out,     // Bad serial frame, pulse
   output logic [15:0]      command_source_select_out, // Setting readback
   output logic [15:0]      terminal_control_mode_out, // Setting readback
   output logic [15:0]      serial_protocol_select_out, // Setting readback
   output logic [7:0]       slave_address_out    // Setting readback
);

   // ************************************************************
   // Declarations
   // ************************************************************
   rcs_rx_state_type rx_state_reg;
   rcs_rx_state_type rx_state_next;
   logic [7:0]       frame_mem [0:7];
   logic [2:0]       rx_count_reg;
   logic [2:0]       tx_index_reg;
   logic [15:0]      crc_reg;
   logic             panel_run_reg;
   logic             serial_run_reg;
   logic             serial_rev_reg;
   logic             term_run;
   logic             term_rev;
   logic             flash_wave;
   logic             run_next;
   logic             rev_next;
   logic             led_next;

   // ************************************************************
   // Source decode
   // ************************************************************
   // Out-of-range source codes select nothing, so the motor stays stopped
   wire sel_panel    = (command_source_select_out == SRC_PANEL);
   wire sel_terminal = (command_source_select_out == SRC_TERMINAL);
   wire sel_serial   = (command_source_select_out == SRC_SERIAL);
   wire proto_modbus = (serial_protocol_select_out == PROTO_MODBUS);

   // ************************************************************
   // Frame decode
   // ************************************************************
   wire [15:0] frame_reg_addr = {frame_mem[2], frame_mem[3]};
   wire [15:0] frame_data     = {frame_mem[4], frame_mem[5]};
   // The CRC byte sent first is the low half of the CRC register
   wire        crc_ok    = (frame_mem[6] == crc_reg[7:0]) &&
                           (frame_mem[7] == crc_reg[15:8]);
   wire        addr_ok   = (frame_mem[0] == slave_address_out);
   wire        cmd_ok    = (frame_mem[1] == FN_WRITE_ONE) &&
                           (frame_reg_addr == CTRL_ADDR);
   wire        frame_ok  = crc_ok & addr_ok & cmd_ok & proto_modbus;
   wire        frame_bad = ~crc_ok | ~cmd_ok;
   wire        rx_take   = rx_valid_in & (rx_state_reg == RX_IDLE ||
                                          rx_state_reg == RX_COLLECT);
   wire        tx_done   = tx_valid_out & tx_ready_in & (tx_index_reg == BYTE_LAST);

   // ************************************************************
   // Terminal decoder and indicator flasher
   // ************************************************************
   rcs_terminal_decode u_term (
      .clk_in      (clk_in),
      .sys_rst_in  (sys_rst_in),
      .ce_in       (ce_in),
      .enable_in   (sel_terminal),
      .mode_in     (terminal_control_mode_out[1:0]),
      .fwd_run_in  (digital_input_1_in),
      .rev_dir_in  (digital_input_2_in),
      .nc_stop_in  (digital_input_3_in),
      .run_out     (term_run),
      .reverse_out (term_rev)
   );

   rcs_flasher #(
      .HALF_CYC (FLASH_CYC)
   ) u_flash (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .ce_in      (ce_in),
      .flash_out  (flash_wave)
   );

   // ************************************************************
   // Settings
   // ************************************************************
   // Written by the panel menu or the parameter port; mode keeps two bits
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         command_source_select_out  <= RST_SOURCE;
         terminal_control_mode_out  <= RST_MODE;
         serial_protocol_select_out <= RST_PROTOCOL;
         slave_address_out          <= RST_SLAVE;
      end else if (ce_in && set_wr_in) begin
         case (set_idx_in)
            SET_SOURCE:   command_source_select_out  <= set_data_in;
            SET_MODE:     terminal_control_mode_out  <= {14'h0000, set_data_in[1:0]};
            SET_PROTOCOL: serial_protocol_select_out <= set_data_in;
            SET_SLAVE:    slave_address_out          <= set_data_in[7:0];
            default:      slave_address_out          <= slave_address_out;
         endcase
      end
   end

   // ************************************************************
   // Panel keys
   // ************************************************************
   // Stop wins over run so a held stop key can never be overridden
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         panel_run_reg <= 1'b0;
      end else if (ce_in) begin
         if (!sel_panel || stop_key_in) begin
            panel_run_reg <= 1'b0;
         end else if (run_key_in) begin
            panel_run_reg <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Serial receive state machine
   // ************************************************************
   always_comb begin
      rx_state_next = rx_state_reg;
      case (rx_state_reg)
         RX_IDLE: begin
            if (rx_valid_in && !rx_gap_in) begin
               rx_state_next = RX_COLLECT;
            end
         end
         RX_COLLECT: begin
            if (rx_gap_in) begin
               rx_state_next = RX_IDLE;
            end else if (rx_valid_in && rx_count_reg == BYTE_LAST) begin
               rx_state_next = RX_CHECK;
            end
         end
         RX_CHECK: begin
            // Only a frame for this drive on the selected link is answered
            if (frame_ok && sel_serial) begin
               rx_state_next = RX_ECHO;
            end else begin
               rx_state_next = RX_DISCARD;
            end
         end
         RX_ECHO: begin
            if (tx_done) begin
               rx_state_next = RX_DISCARD;
            end
         end
         RX_DISCARD: begin
            // Extra bytes wait for the line gap to keep framing aligned
            if (rx_gap_in) begin
               rx_state_next = RX_IDLE;
            end
         end
         default: begin
            rx_state_next = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rx_state_reg <= RX_IDLE;
      end else if (ce_in) begin
         rx_state_reg <= rx_state_next;
      end
   end

   // ************************************************************
   // Frame storage and running CRC
   // ************************************************************
   // Buffer holds data only, so it needs no reset
   always_ff @(posedge clk_in) begin
      if (ce_in && rx_take && !rx_gap_in) begin
         frame_mem[rx_count_reg] <= rx_byte_in;
      end
   end

   // CRC covers the six bytes ahead of the check bytes
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rx_count_reg <= 3'h0;
         crc_reg      <= CRC_INIT;
      end else if (ce_in) begin
         if (rx_gap_in || rx_state_reg == RX_IDLE && !rx_valid_in) begin
            rx_count_reg <= 3'h0;
            crc_reg      <= CRC_INIT;
         end else if (rx_take) begin
            rx_count_reg <= rx_count_reg + 3'h1;
            if (rx_count_reg < 3'h6) begin
               crc_reg <= rcs_crc_step(crc_reg, rx_byte_in);
            end
         end
      end
   end

   // ************************************************************
   // Echo transmitter
   // ************************************************************
   // Bytes are replayed from the buffer, so the answer matches the request
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tx_index_reg <= 3'h0;
         tx_valid_out <= 1'b0;
         tx_byte_out  <= 8'h00;
      end else if (ce_in) begin
         if (rx_state_reg == RX_CHECK && frame_ok && sel_serial) begin
            tx_index_reg <= 3'h0;
            tx_valid_out <= 1'b1;
            tx_byte_out  <= frame_mem[0];
         end else if (tx_valid_out && tx_ready_in) begin
            if (tx_index_reg == BYTE_LAST) begin
               tx_valid_out <= 1'b0;
            end else begin
               tx_index_reg <= tx_index_reg + 3'h1;
               tx_byte_out  <= frame_mem[tx_index_reg + 3'h1];
            end
         end
      end
   end

   // ************************************************************
   // Serial command latch and error flag
   // ************************************************************
   // A frame for another slave is not an error on a shared line
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         serial_run_reg  <= 1'b0;
         serial_rev_reg  <= 1'b0;
         frame_error_out <= 1'b0;
      end else if (ce_in) begin
         frame_error_out <= (rx_state_reg == RX_CHECK) & addr_ok & frame_bad;
         if (!sel_serial) begin
            serial_run_reg <= 1'b0;
            serial_rev_reg <= 1'b0;
         end else if (rx_state_reg == RX_CHECK && frame_ok) begin
            // Forward and reverse run; any other value stops
            serial_run_reg <= (frame_data == CMD_FORWARD) ||
                              (frame_data == CMD_REVERSE);
            serial_rev_reg <= (frame_data == CMD_REVERSE);
         end
      end
   end

   // ************************************************************
   // Output selection
   // ************************************************************
   always_comb begin
      run_next = 1'b0;
      rev_next = 1'b0;
      led_next = 1'b0;
      case (command_source_select_out)
         SRC_PANEL: begin
            run_next = panel_run_reg;
            led_next = 1'b0;
         end
         SRC_TERMINAL: begin
            run_next = term_run;
            rev_next = term_rev;
            led_next = 1'b1;
         end
         SRC_SERIAL: begin
            run_next = serial_run_reg;
            rev_next = serial_rev_reg;
            led_next = flash_wave;
         end
         default: begin
            run_next = 1'b0;
            rev_next = 1'b0;
            led_next = 1'b0;
         end
      endcase
   end

   // Outputs leave from flops so the drive sees glitch-free commands
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         motor_run_out            <= 1'b0;
         motor_reverse_out        <= 1'b0;
         source_indicator_led_out <= 1'b0;
      end else if (ce_in) begin
         motor_run_out            <= run_next;
         motor_reverse_out        <= run_next & rev_next;
         source_indicator_led_out <= led_next;
      end
   end

endmodule

// File: src/rcs_pkg.sv
// Shared constants, types and helpers for the run command source block.
// Assumes a single 125 MHz clock domain and byte-level serial framing.

package rcs_pkg;

   // ************************************************************
   // Command sources, terminal modes and serial protocol codes
   // ************************************************************
   localparam logic [15:0] SRC_PANEL      = 16'h0000;
   localparam logic [15:0] SRC_TERMINAL   = 16'h0001;
   localparam logic [15:0] SRC_SERIAL     = 16'h0002;
   localparam logic [1:0]  MODE_TWO_1     = 2'h0;
   localparam logic [1:0]  MODE_TWO_2     = 2'h1;
   localparam logic [1:0]  MODE_THREE_1   = 2'h2;
   localparam logic [1:0]  MODE_THREE_2   = 2'h3;
   localparam logic [15:0] PROTO_MODBUS   = 16'h0000;

   // ************************************************************
   // Setting port indices and reset values
   // ************************************************************
   localparam logic [1:0]  SET_SOURCE     = 2'h0;
   localparam logic [1:0]  SET_MODE       = 2'h1;
   localparam logic [1:0]  SET_PROTOCOL   = 2'h2;
   localparam logic [1:0]  SET_SLAVE      = 2'h3;
   localparam logic [15:0] RST_SOURCE     = 16'h0000;
   localparam logic [15:0] RST_MODE       = 16'h0000;
   localparam logic [15:0] RST_PROTOCOL   = 16'h0000;
   localparam logic [7:0]  RST_SLAVE      = 8'h01;

   // ************************************************************
   // Serial control frame layout
   // ************************************************************
   localparam logic [7:0]  FN_WRITE_ONE   = 8'h06;
   localparam logic [15:0] CTRL_ADDR      = 16'h2000;
   localparam logic [15:0] CMD_FORWARD    = 16'h0001;
   localparam logic [15:0] CMD_REVERSE    = 16'h0002;
   localparam logic [2:0]  BYTE_LAST      = 3'h7;
   localparam logic [15:0] CRC_INIT       = 16'hFFFF;
   localparam logic [15:0] CRC_POLY       = 16'hA001;

   // ************************************************************
   // Timing: indicator flash half period
   // ************************************************************
   localparam int          CLK_KHZ        = 125000;
   localparam int          FLASH_HALF_MS  = 250;
   localparam int          FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;

   typedef enum logic [2:0] {
      RX_IDLE    = 3'b000,
      RX_COLLECT = 3'b001,
      RX_CHECK   = 3'b010,
      RX_ECHO    = 3'b011,
      RX_DISCARD = 3'b100
   } rcs_rx_state_type;

   // One byte of the reflected CRC-16 used by the serial frames
   function automatic logic [15:0] rcs_crc_step(input logic [15:0] crc,
                                                input logic [7:0]  data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

endpackage

// File: src/rcs_flasher.sv
// Free-running square wave used to flash the source indicator.
// Assumes clk_in and the clock enable of the parent block.
`timescale 1ns/1ns

module rcs_flasher
   import rcs_pkg::*;
#(
   parameter int HALF_CYC = FLASH_HALF_CYC
) (
   input  wire logic clk_in,      // System clock
   input  wire logic sys_rst_in,  // Async reset, active high
   input  wire logic ce_in,       // Clock enable
   output logic      flash_out    // Square wave
);

   logic [31:0] count_reg;

   // ************************************************************
   // Half-period counter; toggles the output at each wrap
   // ************************************************************
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         count_reg <= 32'h0000_0000;
         flash_out <= 1'b0;
      end else if (ce_in) begin
         if (count_reg >= 32'(HALF_CYC - 1)) begin
            count_reg <= 32'h0000_0000;
            flash_out <= ~flash_out;
         end else begin
            count_reg <= count_reg + 32'h0000_0001;
         end
      end
   end

endmodule

// File: src/rcs_terminal_decode.sv
// Terminal run decoder: two-wire and three-wire switch modes.
// Inputs are switch levels, 1 = closed, synchronous to clk_in.
`timescale 1ns/1ns

module rcs_terminal_decode
   import rcs_pkg::*;
(
   input  wire logic       clk_in,         // System clock
   input  wire logic       sys_rst_in,     // Async reset, active high
   input  wire logic       ce_in,          // Clock enable
   input  wire logic       enable_in,      // Terminal source selected
   input  wire logic [1:0] mode_in,        // Terminal control mode
   input  wire logic       fwd_run_in,     // Input 1 level
   input  wire logic       rev_dir_in,     // Input 2 level
   input  wire logic       nc_stop_in,     // Input 3, normally closed stop
   output logic            run_out,        // Run request
   output logic            reverse_out     // Reverse direction
);

   logic fwd_prev_reg;
   logic rev_prev_reg;
   logic run_next;
   logic rev_next;

   // Press detection for the momentary buttons
   wire fwd_press = fwd_run_in & ~fwd_prev_reg;
   wire rev_press = rev_dir_in & ~rev_prev_reg;

   // ************************************************************
   // Mode decode
   // ************************************************************
   always_comb begin
      run_next = 1'b0;
      rev_next = 1'b0;
      case (mode_in)
         MODE_TWO_1: begin
            // Both open or both closed means stop
            run_next = fwd_run_in ^ rev_dir_in;
            rev_next = rev_dir_in & ~fwd_run_in;
         end
         MODE_TWO_2: begin
            run_next = fwd_run_in;
            rev_next = fwd_run_in & rev_dir_in;
         end
         MODE_THREE_1: begin
            if (nc_stop_in) begin
               if (fwd_press) begin
                  run_next = 1'b1;
               end else if (rev_press) begin
                  run_next = 1'b1;
                  rev_next = 1'b1;
               end else begin
                  run_next = run_out;
                  rev_next = reverse_out;
               end
            end
         end
         MODE_THREE_2: begin
            if (nc_stop_in) begin
               run_next = run_out | fwd_press;
               rev_next = (run_out | fwd_press) & rev_dir_in;
            end
         end
         default: begin
            run_next = 1'b0;
            rev_next = 1'b0;
         end
      endcase
   end

   // ************************************************************
   // State; run and reverse cleared while another source owns the motor, press history kept
   // ************************************************************
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         fwd_prev_reg <= 1'b0;
         rev_prev_reg <= 1'b0;
         run_out      <= 1'b0;
         reverse_out  <= 1'b0;
      end else if (ce_in) begin
         fwd_prev_reg <= fwd_run_in;
         rev_prev_reg <= rev_dir_in;
         run_out      <= enable_in & run_next;
         reverse_out  <= enable_in & rev_next;
      end
   end

endmodule

// File: verif/rcs_host_model.sv
// Fieldbus host: silence pulse, then eight bytes; echo taken at half rate.
// Assumes the block answers only after a whole frame and waits for a line gap.
`timescale 1ns/1ns
module rcs_host_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] tx_byte_in,
   input  wire logic       tx_valid_in,
   output logic [7:0]      rx_byte_out = 8'h00,
   output logic            rx_valid_out = 1'b0,
   output logic            rx_gap_out = 1'b0,
   output logic            tx_ready_out = 1'b0
);
   logic [63:0] echo = 64'h0;
   // Ready toggles, so each echo byte waits at most one cycle
   always @(posedge clk_in) begin
      tx_ready_out <= ~tx_ready_out;
      if (tx_valid_in && tx_ready_out) echo <= {echo[55:0], tx_byte_in};
   end
   // Bytes back to back; the idle line never shows a stale byte
   task send(input logic [63:0] f);
      for (int i = 8; i >= -1; i--) begin
         @(posedge clk_in);
         {rx_gap_out, rx_valid_out} <= {i == 8, i >= 0 && i < 8};
         rx_byte_out <= (i >= 0 && i < 8) ? f[i*8+:8] : ~rx_byte_out;
      end
   endtask
endmodule

// File: verif/rcs_command_source_checker.sv
// Port assertions for the run command source; one clock domain.
// Sees only the block's ports and is bound into every instance of the block.
`timescale 1ns/1ns
module rcs_command_source_checker
   import rcs_pkg::*;
(
   input wire logic clk_in, sys_rst_in, ce_in, set_wr_in, stop_key_in, tx_ready_in,
   input wire logic digital_input_1_in, digital_input_2_in, digital_input_3_in,
   input wire logic tx_valid_out, motor_run_out, motor_reverse_out, source_indicator_led_out,
   input wire logic [1:0]  set_idx_in,
   input wire logic [7:0]  tx_byte_out,
   input wire logic [15:0] set_data_in, command_source_select_out, terminal_control_mode_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // Two-wire targets are {run, reverse}
   wire logic [15:0] s   = command_source_select_out;
   wire logic [1:0]  m   = terminal_control_mode_out[1:0];
   wire logic        a   = digital_input_1_in;
   wire logic        b   = digital_input_2_in;
   wire logic [1:0]  mot = {motor_run_out, motor_reverse_out};
   wire logic [1:0]  tw1 = {a ^ b, b & ~a};
   wire logic [1:0]  tw2 = {a, a & b};
   a_source_readback: assert property (ce_in && set_wr_in && set_idx_in == SET_SOURCE
      |=> s == $past(set_data_in)) else $error("source readback");
   a_led_on: assert property (s == SRC_TERMINAL |=> source_indicator_led_out)
      else $error("lamp not on");
   a_led_off: assert property (s == SRC_PANEL |=> !source_indicator_led_out)
      else $error("lamp not off");
   a_panel_stop: assert property (s == SRC_PANEL && stop_key_in ##1 s == SRC_PANEL
      |=> !motor_run_out) else $error("panel stop");
   a_two_wire_one: assert property ((s == SRC_TERMINAL && m == MODE_TWO_1)[*3]
      |-> mot == $past(tw1, 2)) else $error("two-wire mode 1");
   a_two_wire_two: assert property ((s == SRC_TERMINAL && m == MODE_TWO_2)[*3]
      |-> mot == $past(tw2, 2)) else $error("two-wire mode 2");
   a_three_wire_stop: assert property (s == SRC_TERMINAL && m[1] && !digital_input_3_in
      ##1 s == SRC_TERMINAL |=> !motor_run_out) else $error("stop input open");
   a_echo_hold: assert property (tx_valid_out && !tx_ready_in
      |=> tx_valid_out && $stable(tx_byte_out)) else $error("echo dropped");
endmodule
bind rcs_command_source rcs_command_source_checker u_checker (.*);

// File: verif/rcs_command_source_tb.sv
// Bench: panel keys, terminal modes and serial frames through a host model.
// Assumes a four-cycle indicator flash half period, set through the parameter.
`timescale 1ns/1ns
module rcs_command_source_tb;
   logic clk_in = 0, sys_rst_in = 1, ce_in = 1, set_wr_in = 0, run_key_in = 0, stop_key_in = 0;
   logic d1 = 0, d2 = 0, d3 = 0, rx_valid_in, rx_gap_in, tx_ready_in, tx_valid_out, led;
   logic motor_run_out, motor_reverse_out, frame_error_out;
   logic [1:0]  set_idx_in = 0;
   logic [7:0]  rx_byte_in, tx_byte_out, sa, tbl;
   logic [15:0] set_data_in = 0, cs, tm, sp;
   int err_count = 0, samples_checked = 0, cyc = 0, nfe = 0;
   rcs_command_source #(.FLASH_CYC(4)) DUT (.digital_input_1_in(d1), .digital_input_2_in(d2),
      .digital_input_3_in(d3), .source_indicator_led_out(led), .command_source_select_out(cs),
      .terminal_control_mode_out(tm), .serial_protocol_select_out(sp), .slave_address_out(sa), .*);
   rcs_host_model HOST (.clk_in, .tx_byte_in(tx_byte_out), .tx_valid_in(tx_valid_out),
      .rx_byte_out(rx_byte_in), .rx_valid_out(rx_valid_in), .rx_gap_out(rx_gap_in),
      .tx_ready_out(tx_ready_in));
   initial forever #4 clk_in = ~clk_in;
   // Hang guard, and a count of bad-frame pulses
   always @(posedge clk_in) begin
      cyc++;
      nfe += int'(frame_error_out === 1'b1);
      if (cyc == 3000) begin
         err_count++;
         finish_test;
      end
   end
   task finish_test;
      $display("err_count=%0d samples_checked=%0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [71:0] got, input logic [71:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task w(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task setw(input logic [1:0] i, input logic [15:0] d);
      @(posedge clk_in);
      {set_wr_in, set_idx_in, set_data_in} <= {1'b1, i, d};
      @(posedge clk_in);
      set_wr_in <= 0;
      w(1);
   endtask
   // Pins are {run key, stop key, input 1, input 2, input 3}; e is {run, reverse}
   task step(input logic [4:0] v, input logic [1:0] e);
      @(posedge clk_in);
      {run_key_in, stop_key_in, d1, d2, d3} <= v;
      w(3);
      chk({motor_run_out, motor_reverse_out}, e);
   endtask
   // Frame, then motor state and the echo once the host has taken it
   task frame(input logic [63:0] f, input logic [1:0] e, input logic [63:0] x);
      HOST.send(f);
      w(30);
      chk({motor_run_out, motor_reverse_out, HOST.echo}, {e, x});
   endtask
   initial begin
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 0;
      w(1);
      chk({cs, tm, sp, sa}, 56'h01);
      step(5'b10000, 2'b10);
      step(5'b00110, 2'b10);
      step(5'b01000, 2'b00);
      setw(0, 1);
      for (int m = 0; m < 2; m++) begin
         setw(1, m[15:0]);
         tbl = m[0] ? 8'hE0 : 8'h2C;
         for (int i = 0; i < 4; i++)
            step({2'b10, i[1:0], 1'b0}, tbl[2*i+:2]);
      end
      chk({cs, led}, 17'h3);
      setw(1, 2);
      step(5'b00001, 2'b00);
      step(5'b00101, 2'b10);
      step(5'b00011, 2'b11);
      step(5'b00010, 2'b00);
      step(5'b00100, 2'b00);
      setw(1, 3);
      step(5'b00011, 2'b00);
      step(5'b00111, 2'b11);
      step(5'b00101, 2'b10);
      setw(2, 0);
      setw(0, 2);
      // Serial lamp must change over one flash half period of four cycles
      tbl[0] = led;
      w(4);
      chk(led ^ tbl[0], 1);
      frame(64'h01062000000203CB, 2'b11, 64'h01062000000203CB);
      frame(64'h01062000000143CA, 2'b10, 64'h01062000000143CA);
      frame(64'h01062000000143CB, 2'b10, 64'h01062000000143CA);
      chk(nfe, 1);
      frame(64'h0106200000054209, 2'b00, 64'h0106200000054209);
      // Good frames refused under another protocol or another slave address
      setw(2, 1);
      frame(64'h01062000000203CB, 2'b00, 64'h0106200000054209);
      setw(2, 0);
      setw(3, 2);
      frame(64'h01062000000203CB, 2'b00, 64'h0106200000054209);
      chk({nfe, sa, sp}, {32'h0000_0001, 8'h02, 16'h0000});
      finish_test;
   end
endmodule
